// [design/prot_defines.svh]
// constants for the flash protection command host controller
`ifndef PROT_DEFINES_SVH
`define PROT_DEFINES_SVH
`define ADDR_UNLOCK1     23'h000555
`define ADDR_UNLOCK2     23'h0002AA
`define DATA_UNLOCK1     16'h00AA
`define DATA_UNLOCK2     16'h0055
`define CMD_LOCKREG      16'h0040
`define CMD_PASSWORD     16'h0060
`define CMD_NONVOL       16'h00C0
`define CMD_LOCKBIT      16'h0050
`define CMD_VOLATILE     16'h00E0
`define CMD_EXTBLOCK     16'h0088
`define CMD_PROGRAM      16'h00A0
`define CMD_CLEAR1       16'h0080
`define CMD_CLEAR2       16'h0030
`define CMD_EXIT1        16'h0090
`define CMD_EXIT2        16'h0000
`define CMD_PW_UNLOCK1   16'h0025
`define CMD_PW_UNLOCK2   16'h0003
`define CMD_PW_UNLOCK3   16'h0029
`define DATA_PROTECT     16'h0000
`define DATA_UNPROTECT   16'h0001
// apb register offsets
`define REG_CTRL         12'h000
`define REG_ADDR         12'h004
`define REG_WDATA        12'h008
`define REG_STATUS       12'h00C
`define REG_RDATA        12'h010
`define REG_PW01         12'h014
`define REG_PW23         12'h018
// bus cycle timing in cycles of clk
`define WE_LOW_CYCLES    4'h3
`define RD_CYCLES        4'h4
`define GAP_CYCLES       4'h2
`endif

// [design/prot_pkg.sv]
// types for the flash protection command host controller
package prot_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_ENTER_LOCKREG, OP_ENTER_PASSWORD, OP_ENTER_NONVOL, OP_ENTER_LOCKBIT,
    OP_ENTER_VOLATILE, OP_ENTER_EXTBLOCK, OP_PROGRAM, OP_CLEAR_ALL, OP_READ,
    OP_PW_READ, OP_PW_UNLOCK, OP_EXIT_SET, OP_EXIT_EXTBLOCK
  } op_e;
  typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_GAP} cyc_e;
  typedef enum logic [1:0] {SET_NONE, SET_PROT, SET_EXT} set_e;
endpackage

// [design/flash_bus_cycle.sv]
// one asynchronous flash bus cycle, write-strobe controlled
`timescale 1ns/1ps
`include "prot_defines.svh"
module flash_bus_cycle import prot_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,     // one-cycle request
  input  wire logic        is_write,
  input  wire logic [22:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] dq_in,     // already synchronised
  output logic             done,      // one-cycle pulse
  output logic [15:0]      rdata,
  output logic [22:0]      fl_addr,
  output logic [15:0]      fl_dq_out,
  output logic             fl_dq_oe,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n
);
  typedef struct packed {
    cyc_e        st;
    logic [3:0]  cnt;
    logic        wr;
    logic        done;
    logic [15:0] rdata;
    logic [22:0] a;
    logic [15:0] d;
    logic        oe;
    logic        ce_n;
    logic        goe_n;
    logic        we_n;
  } cyc_s;
  cyc_s s_q, s_d;

  // chip select falls first, write strobe alone times the write
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      CYC_IDLE: begin
        if (start) begin
          s_d.st = CYC_SETUP;
          s_d.wr = is_write;
          s_d.a  = addr;
          s_d.d  = wdata;
          s_d.oe = is_write;
          s_d.ce_n = 1'b0;
        end
      end
      CYC_SETUP: begin // strobe asserted after chip select is stable
        s_d.st = CYC_STROBE;
        s_d.cnt = s_q.wr ? `WE_LOW_CYCLES : `RD_CYCLES;
        if (s_q.wr) s_d.we_n = 1'b0;
        else s_d.goe_n = 1'b0;
      end
      CYC_STROBE: begin
        if (s_q.cnt == 4'h1) begin
          s_d.st = CYC_GAP;
          s_d.cnt = `GAP_CYCLES;
          s_d.we_n = 1'b1;  // rising strobe latches data while ce stays low
          s_d.goe_n = 1'b1;
          if (!s_q.wr) s_d.rdata = dq_in;
        end else s_d.cnt = s_q.cnt - 4'h1;
      end
      CYC_GAP: begin // hold data, then release the bus
        s_d.ce_n = 1'b1;
        s_d.oe = 1'b0;
        if (s_q.cnt == 4'h1) begin
          s_d.st = CYC_IDLE;
          s_d.done = 1'b1;
        end else s_d.cnt = s_q.cnt - 4'h1;
      end
    endcase
  end

  // single state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{st: CYC_IDLE, cnt: 4'h0, wr: 1'b0, done: 1'b0, rdata: 16'h0000, a: 23'h000000,
               d: 16'h0000, oe: 1'b0, ce_n: 1'b1, goe_n: 1'b1, we_n: 1'b1};
    end else s_q <= s_d;
  end

  assign done = s_q.done;
  assign rdata = s_q.rdata;
  assign fl_addr = s_q.a;
  assign fl_dq_out = s_q.d;
  assign fl_dq_oe = s_q.oe;
  assign fl_ce_n = s_q.ce_n;
  assign fl_oe_n = s_q.goe_n;
  assign fl_we_n = s_q.we_n;

  a_we_needs_ce: assert property (@(posedge clk) disable iff (reset)
    !fl_we_n |-> !fl_ce_n) else $error("write strobe low without chip select");
  a_we_width: assert property (@(posedge clk) disable iff (reset)
    $fell(fl_we_n) |-> !fl_we_n [*3] ##1 fl_we_n) else $error("write strobe width wrong");
endmodule // flash_bus_cycle

// [design/prot_host.sv]
// apb-driven host that issues flash protection command sequences
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "prot_defines.svh"
// Behaviour
// - upper data byte driven zero in commands
// - lock register entry AA/555 55/2AA 40/555
// - A0 then value programs; read returns it
// - password entry uses command 60
// - password program A0 then one word
// - unlock 25,03, four words, 29 at 00
// - lock-bit entry uses command 50
// - volatile entry uses command E0
// - volatile set/clear, write-strobe timed only
// - entry sequence precedes any set operation
// - exit with 90 then 00
// - extended block entry 88; four-write exit
module prot_host import prot_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] fl_dq_in,
  output logic [15:0]      fl_dq_out,
  output logic             fl_dq_oe,
  output logic [22:0]      fl_addr,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n
);
  typedef struct packed {
    op_e         op;
    logic [3:0]  step;      // bus cycle index within op
    logic        busy;
    logic        issued;    // cycle started, waiting for done
    set_e        set;       // which command set we believe is entered
    logic        err;       // refused op (sticky until next accepted start or OP_NONE write)
    logic [22:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [63:0] pw;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_s;
  host_s s_q, s_d;

  logic [15:0] dq_m_q, dq_s_q;   // pin synchroniser
  logic        cyc_start;
  logic        cyc_wr;
  logic [22:0] cyc_addr;
  logic [15:0] cyc_data;
  logic        cyc_done;
  logic [15:0] cyc_rdata;

  // two flops on data pins before use
  always_ff @(posedge clk) begin
    if (reset) begin
      dq_m_q <= 16'h0000;
      dq_s_q <= 16'h0000;
    end else begin
      dq_m_q <= fl_dq_in;
      dq_s_q <= dq_m_q;
    end
  end

  // number of bus cycles per operation
  function automatic logic [3:0] op_len(input op_e op);
    unique case (op)
      OP_ENTER_LOCKREG, OP_ENTER_PASSWORD, OP_ENTER_NONVOL, OP_ENTER_LOCKBIT,
      OP_ENTER_VOLATILE, OP_ENTER_EXTBLOCK: op_len = 4'h3;
      OP_PROGRAM, OP_CLEAR_ALL, OP_EXIT_SET: op_len = 4'h2;
      OP_READ: op_len = 4'h1;
      OP_PW_READ, OP_EXIT_EXTBLOCK: op_len = 4'h4;
      OP_PW_UNLOCK: op_len = 4'h7;
      default: op_len = 4'h0;
    endcase
  endfunction

  // address of a given cycle; upper bits only carry a block address
  function automatic logic [22:0] cyc_a(input op_e op, input logic [3:0] st, input logic [22:0] ua);
    cyc_a = 23'h000000;
    unique case (op)
      OP_ENTER_LOCKREG, OP_ENTER_PASSWORD, OP_ENTER_NONVOL, OP_ENTER_LOCKBIT,
      OP_ENTER_VOLATILE, OP_ENTER_EXTBLOCK, OP_EXIT_EXTBLOCK:
        cyc_a = (st == 4'h1) ? `ADDR_UNLOCK2 : (st == 4'h3) ? 23'h000000 : `ADDR_UNLOCK1;
      OP_PROGRAM: cyc_a = (st == 4'h0) ? 23'h000000 : ua;
      OP_READ: cyc_a = ua;
      OP_PW_READ: cyc_a = {19'h00000, st};
      OP_PW_UNLOCK: cyc_a = (st >= 4'h2 && st <= 4'h5) ? {19'h00000, st - 4'h2} : 23'h000000;
      default: cyc_a = 23'h000000;
    endcase
  endfunction

  // data of a given cycle; upper data byte driven zero in commands
  function automatic logic [15:0] cyc_d(input op_e op, input logic [3:0] st, input logic [15:0] ud,
                                        input logic [63:0] pw);
    cyc_d = 16'h0000;
    unique case (op)
      OP_ENTER_LOCKREG: cyc_d = (st == 4'h0) ? `DATA_UNLOCK1 : (st == 4'h1) ? `DATA_UNLOCK2 : `CMD_LOCKREG;
      OP_ENTER_PASSWORD: cyc_d = (st == 4'h0) ? `DATA_UNLOCK1 : (st == 4'h1) ? `DATA_UNLOCK2 : `CMD_PASSWORD;
      OP_ENTER_NONVOL: cyc_d = (st == 4'h0) ? `DATA_UNLOCK1 : (st == 4'h1) ? `DATA_UNLOCK2 : `CMD_NONVOL;
      OP_ENTER_LOCKBIT: cyc_d = (st == 4'h0) ? `DATA_UNLOCK1 : (st == 4'h1) ? `DATA_UNLOCK2 : `CMD_LOCKBIT;
      OP_ENTER_VOLATILE: cyc_d = (st == 4'h0) ? `DATA_UNLOCK1 : (st == 4'h1) ? `DATA_UNLOCK2 : `CMD_VOLATILE;
      OP_ENTER_EXTBLOCK: cyc_d = (st == 4'h0) ? `DATA_UNLOCK1 : (st == 4'h1) ? `DATA_UNLOCK2 : `CMD_EXTBLOCK;
      OP_EXIT_EXTBLOCK: cyc_d = (st == 4'h0) ? `DATA_UNLOCK1 : (st == 4'h1) ? `DATA_UNLOCK2 :
                                (st == 4'h2) ? `CMD_EXIT1 : `CMD_EXIT2;
      OP_PROGRAM: cyc_d = (st == 4'h0) ? `CMD_PROGRAM : ud;
      OP_CLEAR_ALL: cyc_d = (st == 4'h0) ? `CMD_CLEAR1 : `CMD_CLEAR2;
      OP_EXIT_SET: cyc_d = (st == 4'h0) ? `CMD_EXIT1 : `CMD_EXIT2;
      OP_PW_UNLOCK: begin
        unique case (st)
          4'h0: cyc_d = `CMD_PW_UNLOCK1;
          4'h1: cyc_d = `CMD_PW_UNLOCK2;
          4'h2: cyc_d = pw[15:0];
          4'h3: cyc_d = pw[31:16];
          4'h4: cyc_d = pw[47:32];
          4'h5: cyc_d = pw[63:48];
          default: cyc_d = `CMD_PW_UNLOCK3;
        endcase
      end
      default: cyc_d = 16'h0000;
    endcase
    // password words are full 16-bit data, not command bytes
    cyc_d[15:8] = ((op == OP_PROGRAM && st == 4'h1) ||
                   (op == OP_PW_UNLOCK && st >= 4'h2 && st <= 4'h5)) ? cyc_d[15:8] : 8'h00;
  endfunction

  // true for operations allowed only inside an entered set
  function automatic logic needs_set(input op_e op);
    needs_set = (op == OP_PROGRAM) || (op == OP_CLEAR_ALL) || (op == OP_PW_READ) ||
                (op == OP_PW_UNLOCK) || (op == OP_EXIT_SET);
  endfunction

  // apb slave, sequencer and status in one state update
  always_comb begin
    logic acc;
    logic [3:0] len;
    acc = psel && penable && !s_q.pready;
    len = op_len(s_q.op);
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // apb access answered one cycle after penable rises
    if (acc) begin
      s_d.pready = 1'b1;
      if (pwrite) begin
        unique case (paddr)
          `REG_CTRL: begin
            if (s_q.busy) s_d.err = 1'b1;   // refused while a sequence runs
            else if (op_e'(pwdata[3:0]) == OP_NONE) s_d.err = 1'b0;
            else if (needs_set(op_e'(pwdata[3:0])) && s_q.set == SET_NONE) s_d.err = 1'b1;
            else begin
              s_d.op = op_e'(pwdata[3:0]);
              s_d.step = 4'h0;
              s_d.busy = 1'b1;
              s_d.err = 1'b0;
            end
          end
          `REG_ADDR: s_d.addr = pwdata[22:0];
          `REG_WDATA: s_d.wdata = pwdata[15:0];
          `REG_PW01: s_d.pw[31:0] = pwdata;
          `REG_PW23: s_d.pw[63:32] = pwdata;
          `REG_STATUS, `REG_RDATA: ;
          default: s_d.pslverr = 1'b1;   // unmapped
        endcase
      end else begin
        unique case (paddr)
          `REG_CTRL: s_d.prdata = {28'h0000000, s_q.op};
          `REG_ADDR: s_d.prdata = {9'h000, s_q.addr};
          `REG_WDATA: s_d.prdata = {16'h0000, s_q.wdata};
          `REG_STATUS: s_d.prdata = {28'h0000000, s_q.set, s_q.err, s_q.busy};
          `REG_RDATA: s_d.prdata = {16'h0000, s_q.rdata};
          `REG_PW01: s_d.prdata = s_q.pw[31:0];
          `REG_PW23: s_d.prdata = s_q.pw[63:32];
          default: begin
            s_d.prdata = 32'h00000000;
            s_d.pslverr = 1'b1;
          end
        endcase
      end
    end
    // sequencer: one bus cycle at a time
    if (s_q.busy && cyc_done) begin
      s_d.issued = 1'b0;
      if (s_q.op == OP_READ) s_d.rdata = cyc_rdata;
      if (s_q.op == OP_PW_READ) begin
        unique case (s_q.step[1:0])
          2'h0: s_d.pw[15:0] = cyc_rdata;
          2'h1: s_d.pw[31:16] = cyc_rdata;
          2'h2: s_d.pw[47:32] = cyc_rdata;
          2'h3: s_d.pw[63:48] = cyc_rdata;
        endcase
      end
      if (s_q.step + 4'h1 == len) begin
        s_d.busy = 1'b0;
        s_d.op = OP_NONE;
        unique case (s_q.op)
          OP_ENTER_LOCKREG, OP_ENTER_PASSWORD, OP_ENTER_NONVOL, OP_ENTER_LOCKBIT,
          OP_ENTER_VOLATILE: s_d.set = SET_PROT;
          OP_ENTER_EXTBLOCK: s_d.set = SET_EXT;
          OP_EXIT_SET, OP_EXIT_EXTBLOCK: s_d.set = SET_NONE;
          default: ;
        endcase
      end else s_d.step = s_q.step + 4'h1;
    end else if (s_q.busy && !s_q.issued) s_d.issued = 1'b1;
  end

  assign cyc_start = s_q.busy && !s_q.issued;
  assign cyc_wr = !(s_q.op == OP_READ || s_q.op == OP_PW_READ);
  assign cyc_addr = cyc_a(s_q.op, s_q.step, s_q.addr);
  assign cyc_data = cyc_d(s_q.op, s_q.step, s_q.wdata, s_q.pw);

  // state register; reset leaves no set entered
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{op: OP_NONE, step: 4'h0, busy: 1'b0, issued: 1'b0, set: SET_NONE, err: 1'b0,
               addr: 23'h000000, wdata: 16'h0000, rdata: 16'h0000, pw: 64'h0000000000000000,
               prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
    end else s_q <= s_d;
  end

  // bus cycle engine drives pins from its own flops
  flash_bus_cycle u_cycle (
    .clk       (clk),
    .reset     (reset),
    .start     (cyc_start),
    .is_write  (cyc_wr),
    .addr      (cyc_addr),
    .wdata     (cyc_data),
    .dq_in     (dq_s_q),
    .done      (cyc_done),
    .rdata     (cyc_rdata),
    .fl_addr   (fl_addr),
    .fl_dq_out (fl_dq_out),
    .fl_dq_oe  (fl_dq_oe),
    .fl_ce_n   (fl_ce_n),
    .fl_oe_n   (fl_oe_n),
    .fl_we_n   (fl_we_n)
  );

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

  a_entry_unlock1: assert property (@(posedge clk) disable iff (reset)
    $fell(fl_we_n) && s_q.op == OP_ENTER_LOCKREG && s_q.step == 4'h0 |->
      fl_addr == `ADDR_UNLOCK1 && fl_dq_out == `DATA_UNLOCK1) else $error("bad first unlock");
  a_lockreg_cmd: assert property (@(posedge clk) disable iff (reset)
    $fell(fl_we_n) && s_q.op == OP_ENTER_LOCKREG && s_q.step == 4'h2 |->
      fl_dq_out == `CMD_LOCKREG) else $error("bad lock register entry");
  a_upper_zero: assert property (@(posedge clk) disable iff (reset)
    !fl_we_n && s_q.op != OP_PROGRAM && !(s_q.op == OP_PW_UNLOCK && s_q.step >= 4'h2 && s_q.step <= 4'h5)
    |-> fl_dq_out[15:8] == 8'h00) else $error("upper byte set");
  a_exit_code: assert property (@(posedge clk) disable iff (reset)
    $fell(fl_we_n) && s_q.op == OP_EXIT_SET |-> fl_dq_out == (s_q.step == 4'h0 ? `CMD_EXIT1 : `CMD_EXIT2))
    else $error("bad exit code");
  a_pw_unlock_end: assert property (@(posedge clk) disable iff (reset)
    $fell(fl_we_n) && s_q.op == OP_PW_UNLOCK && s_q.step == 4'h6 |-> fl_dq_out == `CMD_PW_UNLOCK3)
    else $error("bad unlock end");
  a_pw_read_addr: assert property (@(posedge clk) disable iff (reset)
    $fell(fl_oe_n) && s_q.op == OP_PW_READ |-> fl_addr == {19'h00000, s_q.step}) else $error("bad pw addr");
  a_no_set_refused: assert property (@(posedge clk) disable iff (reset)
    s_q.set == SET_NONE && !s_q.busy |=> !(s_q.busy && needs_set(s_q.op))) else $error("op outside set");
  a_pready_pulse: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready) else $error("pready held");
  a_clear_order: assert property (@(posedge clk) disable iff (reset)
    $fell(fl_we_n) && s_q.op == OP_CLEAR_ALL && s_q.step == 4'h1 |-> fl_dq_out == `CMD_CLEAR2)
    else $error("bad clear");
  c_enter: cover property (@(posedge clk) disable iff (reset) $rose(s_q.set == SET_PROT));
  c_ext: cover property (@(posedge clk) disable iff (reset) $rose(s_q.set == SET_EXT));
  c_unlock: cover property (@(posedge clk) disable iff (reset) s_q.op == OP_PW_UNLOCK && cyc_done);
  c_read: cover property (@(posedge clk) disable iff (reset) s_q.op == OP_READ && cyc_done);
endmodule // prot_host

// [tb/flash_dev_model.sv]
// behavioural flash device: protection command sets, write log, read answers
`timescale 1ns/1ps
module flash_dev_model (
  input  wire logic [22:0] fl_addr,
  input  wire logic [15:0] fl_dq_out,
  input  wire logic        fl_dq_oe,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  output logic      [15:0] fl_dq_in
);
  logic [22:0]  wa [0:63];  // logged write addresses
  logic [15:0]  wd [0:63];  // logged write data
  int           n_w = 0;    // writes logged
  int           n_bad = 0;  // writes not timed by we_n inside ce_n low
  logic         arm = 0;    // we_n fell with chip selected
  logic [7:0]   set_q = 0;  // entered command set, 0 in read mode
  logic [7:0]   h1 = 0;     // previous write data
  logic [7:0]   h2 = 0;     // write data before that
  logic [15:0]  a1 = 0;     // previous write address
  logic [15:0]  a2 = 0;     // address before that
  logic [15:0]  lockreg_q = 16'hFFFF;
  logic [15:0]  pw_q [0:3] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
  logic         lockbit_q = 1'b1;
  logic [127:0] nv_q = '1;  // 1 means unprotected
  logic [127:0] vb_q = '1;
  logic [15:0]  rd_v;       // value answered on a read
  logic [15:0]  last_q = 0; // last value driven, inverted once released
  logic [15:0]  w;          // wire level during a write
  logic [7:0]   d;
  logic [6:0]   blk;
  // only we_n-controlled cycles count; ce_n must wrap the pulse
  always @(negedge fl_we_n) begin
    arm = (fl_ce_n === 1'b0);
    if (!arm) n_bad++;
  end
  // decode on the rising write strobe
  always @(posedge fl_we_n) begin
    if (arm) begin
      w = fl_dq_oe ? fl_dq_out : fl_dq_in;
      if (fl_ce_n !== 1'b0) n_bad++;
      wa[n_w] = fl_addr;
      wd[n_w] = w;
      n_w++;
      d = w[7:0];
      blk = fl_addr[22:16];
      // unlock pair then command at 555, upper address ignored
      // a cycle matching nothing below just shifts history, dropping the partial sequence
      if (h2 == 8'hAA && a2 == 16'h0555 && h1 == 8'h55 && a1 == 16'h02AA && fl_addr[15:0] == 16'h0555)
        set_q = d;
      else if (h1 == 8'h90 && d == 8'h00) set_q = 0;
      else if (h1 == 8'h80 && d == 8'h30 && set_q == 8'hC0) begin
        nv_q = '0;
        nv_q = '1;
      end else if (h1 == 8'hA0) begin
        case (set_q)
          8'h40: lockreg_q = w;
          8'h60: pw_q[fl_addr[1:0]] = w;
          8'hC0: if (lockbit_q) nv_q[blk] = 1'b0;
          8'h50: lockbit_q = 1'b0;
          8'hE0: vb_q[blk] = d[0];
          default: ;
        endcase
      end
      h2 = h1;
      a2 = a1;
      h1 = d;
      a1 = fl_addr[15:0];
    end
    arm = 0;
  end
  // read answer depends on the entered set
  always_comb begin
    case (set_q)
      8'h40: rd_v = lockreg_q;
      8'h60: rd_v = pw_q[fl_addr[1:0]];
      8'hC0: rd_v = {15'h0, nv_q[fl_addr[22:16]]};
      8'h50: rd_v = {15'h0, lockbit_q};
      8'hE0: rd_v = {15'h0, vb_q[fl_addr[22:16]]};
      default: rd_v = 16'h1234 ^ fl_addr[15:0];
    endcase
  end
  // released bus shows the inverse so a stale sample cannot pass
  always @(posedge fl_oe_n) last_q = rd_v;
  assign fl_dq_in = (fl_ce_n === 1'b0 && fl_oe_n === 1'b0) ? rd_v : ~last_q;
endmodule // flash_dev_model

// [tb/prot_host_tb.sv]
// self-checking bench for the protection command host
`timescale 1ns/1ps
`include "prot_defines.svh"
module prot_host_tb import prot_pkg::*;;
  logic        clk = 0;
  logic        reset = 1;
  logic [11:0] paddr = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] fl_dq_in;
  logic [15:0] fl_dq_out;
  logic        fl_dq_oe;
  logic [22:0] fl_addr;
  logic        fl_ce_n;
  logic        fl_oe_n;
  logic        fl_we_n;
  int          failures = 0;
  int          n_checks = 0;
  int          wp = 0;    // next write log entry to compare
  logic [31:0] rd_q;      // last apb read data
  logic        slv_q;     // last apb error flag
  always #12.5 clk = ~clk;
  prot_host u_dut (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n));
  flash_dev_model u_dev (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_in(fl_dq_in));
  // one comparison, counted
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // apb transfer: setup, access held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wdat);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wdat;
    penable <= 0;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd_q = prdata;
    slv_q = pslverr;
    if (k >= 50) chk(0, 1);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // load address and data, start op, poll busy
  task run_op(input op_e op, input logic [22:0] a, input logic [15:0] dv);
    int k;
    apb(1, `REG_ADDR, {9'h0, a});
    apb(1, `REG_WDATA, {16'h0, dv});
    apb(1, `REG_CTRL, {28'h0, op});
    k = 0;
    do begin
      apb(0, `REG_STATUS, 0);
      k++;
    end while (rd_q[0] !== 1'b0 && k < 200);
    if (k >= 200) chk(0, 1);
  endtask
  task chk_w(input logic [22:0] a, input logic [15:0] dv);
    chk({u_dev.wa[wp], u_dev.wd[wp]}, {a, dv});
    wp++;
  endtask
  task chk_d(input logic [15:0] dv); // address is free for these cycles
    chk(u_dev.wd[wp], dv);
    wp++;
  endtask
  task enter(input op_e op, input logic [15:0] cmd, input logic [1:0] st);
    run_op(op, 0, 0);
    chk_w(23'h000555, 16'h00AA);
    chk_w(23'h0002AA, 16'h0055);
    chk_w(23'h000555, cmd);
    apb(0, `REG_STATUS, 0);
    chk(rd_q[3:2], st);
  endtask
  task leave;
    run_op(OP_EXIT_SET, 0, 0);
    chk_d(16'h0090);
    chk_d(16'h0000);
    chk(u_dev.n_w, wp);
    chk(u_dev.n_bad, 0);
  endtask
  task rd_chk(input logic [22:0] a, input logic [15:0] e);
    run_op(OP_READ, a, 0);
    apb(0, `REG_RDATA, 0);
    chk(rd_q[15:0], e);
  endtask
  task t_idle;
    chk({fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe}, 4'hE);
    apb(0, `REG_STATUS, 0);
    chk(rd_q[3:2], 0);
    apb(0, 12'h0FC, 0);
    chk(slv_q, 1);
    run_op(OP_PROGRAM, 23'h000010, 16'h0000);
    chk(rd_q[1], 1);
    chk(u_dev.n_w, 0);
    $display("test idle done");
  endtask
  task t_lockreg;
    enter(OP_ENTER_LOCKREG, 16'h0040, SET_PROT);
    run_op(OP_PROGRAM, 23'h000007, 16'hFFFB);
    chk_w(0, 16'h00A0);
    chk_w(23'h000007, 16'hFFFB);
    rd_chk(23'h000003, 16'hFFFB);
    leave();
    $display("test lockreg done");
  endtask
  task t_password;
    enter(OP_ENTER_PASSWORD, 16'h0060, SET_PROT);
    run_op(OP_PROGRAM, 23'h000001, 16'h5A5A);
    chk_w(0, 16'h00A0);
    chk_w(23'h000001, 16'h5A5A);
    run_op(OP_PW_READ, 0, 0);
    apb(0, `REG_PW01, 0);
    chk(rd_q, 32'h5A5A_1111);
    apb(0, `REG_PW23, 0);
    chk(rd_q, 32'h4444_3333);
    apb(1, `REG_PW01, 32'hB2B2_A1A1);
    apb(1, `REG_PW23, 32'hD4D4_C3C3);
    run_op(OP_PW_UNLOCK, 0, 0);
    chk_w(0, 16'h0025);
    chk_w(0, 16'h0003);
    chk_w(0, 16'hA1A1);
    chk_w(23'h000001, 16'hB2B2);
    chk_w(23'h000002, 16'hC3C3);
    chk_w(23'h000003, 16'hD4D4);
    chk_w(0, 16'h0029);
    leave();
    $display("test password done");
  endtask
  task t_nonvol;
    enter(OP_ENTER_NONVOL, 16'h00C0, SET_PROT);
    run_op(OP_PROGRAM, 23'h030000, 16'h0000);
    chk_w(0, 16'h00A0);
    chk_w(23'h030000, 16'h0000);
    rd_chk(23'h030004, 16'h0000);
    run_op(OP_CLEAR_ALL, 0, 0);
    chk_d(16'h0080);
    chk_w(0, 16'h0030);
    rd_chk(23'h030004, 16'h0001);
    leave();
    $display("test nonvol done");
  endtask
  task t_sets;
    enter(OP_ENTER_LOCKBIT, 16'h0050, SET_PROT);
    rd_chk(23'h000100, 16'h0001);
    run_op(OP_PROGRAM, 23'h000100, 16'h0000);
    chk_w(0, 16'h00A0);
    chk_w(23'h000100, 16'h0000);
    rd_chk(23'h000100, 16'h0000);
    leave();
    enter(OP_ENTER_VOLATILE, 16'h00E0, SET_PROT);
    for (int v = 0; v < 2; v++) begin
      run_op(OP_PROGRAM, 23'h050000, 16'(v));
      chk_w(0, 16'h00A0);
      chk_w(23'h050000, 16'(v));
      rd_chk(23'h050002, 16'(v));
    end
    leave();
    enter(OP_ENTER_EXTBLOCK, 16'h0088, SET_EXT);
    run_op(OP_EXIT_EXTBLOCK, 0, 0);
    chk_w(23'h000555, 16'h00AA);
    chk_w(23'h0002AA, 16'h0055);
    chk_w(23'h000555, 16'h0090);
    chk_d(16'h0000);
    apb(0, `REG_STATUS, 0);
    chk(rd_q[3:2], 0);
    $display("test sets done");
  endtask
  task t_midreset;
    enter(OP_ENTER_VOLATILE, 16'h00E0, SET_PROT);
    reset <= 1;
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    apb(0, `REG_STATUS, 0);
    chk(rd_q[3:2], 0);
    chk({fl_ce_n, fl_we_n, fl_dq_oe}, 3'h6);
    $display("test midreset done");
  endtask
  // watchdog, far beyond the expected run length
  initial begin
    #(25 * 60000);
    failures++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_idle();
    t_lockreg();
    t_password();
    t_nonvol();
    t_sets();
    t_midreset();
    test_done();
  end
endmodule // prot_host_tb
